// *** hdl/cc_gauge.sv ***
// Functional notes
// - full count from two three-level pins; scale
// - self-discharge rate pin: /64, /47, off
// - display select: off, activity, always on
// - charge counter bounded by capacity and zero
// - charge counter init and early-empty clear
// - discharge counter runs, stops at early-empty
// - self-discharge counts only before charge zero
// - discharge counter clears at full, saturates
// - qualified discharge copies into learned capacity
// - valid-discharge flag tracks qualification
// - charge pulses count up; display above 4mV
// - valid charge after 256 sustained counts
// - steady charge output below 94% of learned capacity, at 0 C or above
// - one-sixteenth pulsing below learned capacity
// - two-hour pulsed top-off after full
// - release on top-off end, temp, voltage, inhibit
// - re-arm top-off at 0.8 of reference
// - over-temperature hold until 10 C cooler
// - empty flags latch until valid charge
// - learned capacity starts at full count
`timescale 1ns/1ps
module cc_gauge #(
  parameter int HALF_CYC = cc_pkg::HALF_SEC_CYC,
  parameter int TOPOFF_HALVES = cc_pkg::TOPOFF_HALVES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] full_count_a_pin,
  input wire logic [1:0] full_count_b_pin,
  input wire logic [1:0] scale_a_pin,
  input wire logic [1:0] scale_b_pin,
  input wire logic [1:0] self_discharge_select_pin,
  input wire logic [1:0] display_mode_pin,
  input wire logic [1:0] display_select_pin,
  input wire logic charge_count_pulse,
  input wire logic discharge_count_pulse,
  input wire logic sense_above_filter,
  input wire logic sense_above_4mv,
  input wire logic sense_below_neg4mv,
  input wire logic cell_below_early,
  input wire logic cell_below_final,
  input wire logic cell_voltage_in_range,
  input wire logic [3:0] temp_step,
  output logic charge_control_out_n,
  output logic led_enable,
  output logic empty_flag
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [1:0] sd_sel_ff, mode_ff, display_select_pin_ff;
  logic [15:0] pfc_ff, nac_ff, lmd_ff, dcr_ff, sdc_ff, vchg_cnt_ff;
  logic [2:0] scale_ff;
  logic early_ff, final_ff, vdq_ff, arm_ff, vchg_ff, ot_ff;
  logic topoff_done_ff, inhibit_ff, chg_n_ff, led_ff, sd_hit_ff;
  logic [31:0] half_cnt_ff, sd_acc_ff, topoff_cnt_ff;
  logic [3:0] phase_ff;
  logic half_tick_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic [15:0] pfc_pins = cc_pkg::pfc_sel(full_count_a_pin, full_count_b_pin);
  wire logic at_full = (nac_ff == lmd_ff);
  wire logic nac_zero = (nac_ff == 16'h0000);
  wire logic chg_step = charge_count_pulse;
  wire logic dis_step = !chg_step && discharge_count_pulse;
  wire logic sd_step = !chg_step && !dis_step && sd_hit_ff && !nac_zero;
  wire logic early_hit = cell_below_early && !early_ff;
  wire logic vchg_hit = sense_above_filter && chg_step && !vchg_ff
    && (vchg_cnt_ff == cc_pkg::VALID_CHG_COUNTS);
  wire logic xfer = chg_step && arm_ff && vdq_ff;
  wire logic [15:0] ref_full = (mode_ff == cc_pkg::LVL_L) ? lmd_ff : pfc_ff;
  wire logic [23:0] nac_w = {8'h00, nac_ff};
  wire logic below_94 = (nac_w * cc_pkg::FULL_DEN) < ({8'h00, lmd_ff} * cc_pkg::FULL_NUM);
  wire logic below_80 = (nac_w * cc_pkg::REARM_DEN) < ({8'h00, ref_full} * cc_pkg::REARM_NUM);
  wire logic temp_hot = (temp_step >= cc_pkg::TEMP_50C);
  wire logic temp_cool = (temp_step < cc_pkg::TEMP_40C);
  wire logic safe = cell_voltage_in_range && !temp_hot && !ot_ff && !inhibit_ff;
  wire logic cont_ok = safe && below_94 && (temp_step >= cc_pkg::TEMP_0C);
  wire logic pulse_ok = safe && (nac_ff < lmd_ff);
  wire logic topoff_ok = safe && at_full && !topoff_done_ff;
  wire logic [31:0] sd_limit = (sd_sel_ff == cc_pkg::LVL_L) ? cc_pkg::SD_LIMIT_L
    : cc_pkg::SD_LIMIT_Z;
  wire logic [31:0] sd_sum = sd_acc_ff + {16'h0000, nac_ff};
  wire logic sd_on = (sd_sel_ff != cc_pkg::LVL_H);
  wire logic aw_take = s_axi_awvalid && awready_ff;
  wire logic w_take = s_axi_wvalid && wready_ff;
  wire logic do_wr = !awready_ff && !wready_ff && !bvalid_ff;
  wire logic b_done = bvalid_ff && s_axi_bready;
  wire logic ar_take = s_axi_arvalid && arready_ff;
  wire logic r_done = rvalid_ff && s_axi_rready;
  wire logic wr_ctrl = do_wr && (awaddr_ff == cc_pkg::REG_CTRL);
  wire logic [31:0] stat_word = {22'h0, sd_hit_ff, topoff_done_ff, ot_ff, !chg_n_ff,
    led_ff, vchg_ff, arm_ff, vdq_ff, final_ff, early_ff};
  wire logic [31:0] cfg_word = {17'h0, scale_ff, display_select_pin_ff, mode_ff, sd_sel_ff, 6'h0};
  wire logic ar_hit = (s_axi_araddr <= cc_pkg::REG_CFG) && (s_axi_araddr[1:0] == 2'h0);
  wire logic aw_hit = (awaddr_ff <= cc_pkg::REG_CFG) && (awaddr_ff[1:0] == 2'h0);
  logic [31:0] rd_word;
  logic [15:0] nxt_nac, nxt_dcr;

  always_comb
  begin
    unique case (s_axi_araddr)
      cc_pkg::REG_CTRL: rd_word = {31'h0, inhibit_ff};
      cc_pkg::REG_STAT: rd_word = stat_word;
      cc_pkg::REG_NAC: rd_word = {16'h0, nac_ff};
      cc_pkg::REG_LMD: rd_word = {16'h0, lmd_ff};
      cc_pkg::REG_DCR: rd_word = {16'h0, dcr_ff};
      cc_pkg::REG_CFG: rd_word = cfg_word;
      default: rd_word = 32'h0;
    endcase
  end

  // ----------------------------------------
  // counters
  // ----------------------------------------
  always_comb
  begin
    nxt_nac = nac_ff;
    if (early_hit)
      nxt_nac = 16'h0000;
    else if (chg_step && nac_ff < lmd_ff)
      nxt_nac = 16'(nac_ff + 16'h0001);
    else if ((dis_step && !nac_zero) || sd_step)
      nxt_nac = 16'(nac_ff - 16'h0001);
    nxt_dcr = dcr_ff;
    if (at_full)
      nxt_dcr = 16'h0000;
    else if (!early_ff && (dis_step || sd_step) && dcr_ff != cc_pkg::DCR_MAX)
      nxt_dcr = 16'(dcr_ff + 16'h0001);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sd_sel_ff <= self_discharge_select_pin;
      mode_ff <= display_mode_pin;
      display_select_pin_ff <= display_select_pin;
      pfc_ff <= pfc_pins;
      scale_ff <= cc_pkg::scale_sel(scale_a_pin, scale_b_pin);
      lmd_ff <= pfc_pins;
      nac_ff <= (display_mode_pin == cc_pkg::LVL_H) ? pfc_pins : cc_pkg::NAC_RST;
      dcr_ff <= 16'h0000;
    end
    else
    begin
      nac_ff <= nxt_nac;
      dcr_ff <= nxt_dcr;
      if (xfer)
        lmd_ff <= dcr_ff;
    end
  end

  // ----------------------------------------
  // qualification
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      early_ff <= 1'h0;
      final_ff <= 1'h0;
      vdq_ff <= 1'h0;
      arm_ff <= 1'h0;
      vchg_ff <= 1'h0;
      vchg_cnt_ff <= 16'h0000;
      sdc_ff <= 16'h0000;
    end
    else
    begin
      early_ff <= cell_below_early || (early_ff && !vchg_hit);
      final_ff <= cell_below_final || (final_ff && !vchg_hit);
      if (!sense_above_filter)
        vchg_cnt_ff <= 16'h0000;
      else if (chg_step && vchg_cnt_ff != cc_pkg::VALID_CHG_COUNTS)
        vchg_cnt_ff <= 16'(vchg_cnt_ff + 16'h0001);
      vchg_ff <= sense_above_filter && (vchg_ff || vchg_hit);
      if (at_full)
        sdc_ff <= 16'h0000;
      else if (sd_step && sdc_ff <= cc_pkg::SD_MAX_COUNTS)
        sdc_ff <= 16'(sdc_ff + 16'h0001);
      if (at_full)
        vdq_ff <= 1'h1;
      else if (vchg_hit || sdc_ff > cc_pkg::SD_MAX_COUNTS || xfer)
        vdq_ff <= 1'h0;
      else if (early_hit && temp_step < cc_pkg::TEMP_0C)
        vdq_ff <= 1'h0;
      if (early_hit)
        arm_ff <= 1'h1;
      else if (chg_step)
        arm_ff <= 1'h0;
    end
  end

  // ----------------------------------------
  // time base and self-discharge
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      half_cnt_ff <= 32'h0;
      half_tick_ff <= 1'h0;
      phase_ff <= 4'h0;
      sd_acc_ff <= 32'h0;
      sd_hit_ff <= 1'h0;
    end
    else
    begin
      half_tick_ff <= (half_cnt_ff == 32'(HALF_CYC - 1));
      half_cnt_ff <= (half_cnt_ff == 32'(HALF_CYC - 1)) ? 32'h0 : half_cnt_ff + 32'h1;
      if (half_tick_ff)
        phase_ff <= 4'(phase_ff + 4'h1);
      sd_hit_ff <= 1'h0;
      if (!sd_on)
        sd_acc_ff <= 32'h0;
      else if (half_tick_ff && sd_sum >= sd_limit)
      begin
        sd_acc_ff <= sd_sum - sd_limit;
        sd_hit_ff <= 1'h1;
      end
      else if (half_tick_ff)
        sd_acc_ff <= sd_sum;
    end
  end

  // ----------------------------------------
  // charge control and display
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ot_ff <= 1'h0;
      topoff_cnt_ff <= 32'h0;
      topoff_done_ff <= 1'h0;
      chg_n_ff <= 1'h1;
      led_ff <= 1'h0;
    end
    else
    begin
      ot_ff <= temp_hot || (ot_ff && !temp_cool);
      if (below_80)
      begin
        topoff_done_ff <= 1'h0;
        topoff_cnt_ff <= 32'h0;
      end
      else if (topoff_ok && half_tick_ff)
      begin
        topoff_cnt_ff <= topoff_cnt_ff + 32'h1;
        topoff_done_ff <= (topoff_cnt_ff == 32'(TOPOFF_HALVES - 1));
      end
      chg_n_ff <= !(cont_ok || ((pulse_ok || topoff_ok) && phase_ff == 4'h0));
      unique case (display_select_pin_ff)
        cc_pkg::LVL_H: led_ff <= 1'h0;
        cc_pkg::LVL_L: led_ff <= 1'h1;
        default: led_ff <= sense_below_neg4mv || sense_above_4mv || vchg_ff;
      endcase
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'h1;
      wready_ff <= 1'h1;
      bvalid_ff <= 1'h0;
      bresp_ff <= cc_pkg::RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      inhibit_ff <= cc_pkg::CTRL_INHIBIT_RST;
    end
    else
    begin
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      awready_ff <= aw_take ? 1'h0 : (b_done ? 1'h1 : awready_ff);
      wready_ff <= w_take ? 1'h0 : (b_done ? 1'h1 : wready_ff);
      if (do_wr)
      begin
        bvalid_ff <= 1'h1;
        bresp_ff <= aw_hit ? cc_pkg::RESP_OKAY : cc_pkg::RESP_DECERR;
      end
      else if (b_done)
        bvalid_ff <= 1'h0;
      if (wr_ctrl && wstrb_ff[0])
        inhibit_ff <= wdata_ff[cc_pkg::CTRL_INHIBIT];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'h1;
      rvalid_ff <= 1'h0;
      rdata_ff <= 32'h0;
      rresp_ff <= cc_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready_ff <= 1'h0;
      rvalid_ff <= 1'h1;
      rdata_ff <= rd_word;
      rresp_ff <= ar_hit ? cc_pkg::RESP_OKAY : cc_pkg::RESP_DECERR;
    end
    else if (r_done)
    begin
      arready_ff <= 1'h1;
      rvalid_ff <= 1'h0;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign charge_control_out_n = chg_n_ff;
  assign led_enable = led_ff;
  assign empty_flag = final_ff;
endmodule // cc_gauge

// *** hdl/cc_pkg.sv ***
package cc_pkg;
  // ----------------------------------------
  // three-level pin codes
  // ----------------------------------------
  localparam logic [1:0] LVL_L = 2'h0;
  localparam logic [1:0] LVL_Z = 2'h1;
  localparam logic [1:0] LVL_H = 2'h2;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_NAC = 8'h08;
  localparam logic [7:0] REG_LMD = 8'h0c;
  localparam logic [7:0] REG_DCR = 8'h10;
  localparam logic [7:0] REG_CFG = 8'h14;
  localparam int CTRL_INHIBIT = 0;
  localparam logic CTRL_INHIBIT_RST = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYC = HALF_SEC_MS * 1000 * CLK_MHZ;
  localparam int TOPOFF_HOURS = 2;
  localparam int TOPOFF_HALVES = TOPOFF_HOURS * 3600 * 2;
  localparam int DAY_HALVES = 86400 * 2;
  localparam logic [31:0] SD_LIMIT_Z = 32'(64 * DAY_HALVES);
  localparam logic [31:0] SD_LIMIT_L = 32'(47 * DAY_HALVES);
  // ----------------------------------------
  // counts and limits
  // ----------------------------------------
  localparam logic [15:0] VALID_CHG_COUNTS = 16'h0100;
  localparam logic [15:0] SD_MAX_COUNTS = 16'h1000;
  localparam logic [15:0] DCR_MAX = 16'hffff;
  localparam logic [15:0] NAC_RST = 16'h0000;
  localparam logic [23:0] FULL_NUM = 24'h00005e;
  localparam logic [23:0] FULL_DEN = 24'h000064;
  localparam logic [23:0] REARM_NUM = 24'h000004;
  localparam logic [23:0] REARM_DEN = 24'h000005;
  // temperature steps of 10 degrees, step 4 is 0 to 10 C
  localparam logic [3:0] TEMP_0C = 4'h4;
  localparam logic [3:0] TEMP_40C = 4'h8;
  localparam logic [3:0] TEMP_50C = 4'h9;
  // ----------------------------------------
  // full count selection
  // ----------------------------------------
  function automatic logic [15:0] pfc_sel(input logic [1:0] a, input logic [1:0] b);
    logic [3:0] k;
    k = {a, b};
    unique case (k)
      {LVL_H, LVL_H}: pfc_sel = 16'hc000;
      {LVL_H, LVL_Z}: pfc_sel = 16'hb000;
      {LVL_H, LVL_L}: pfc_sel = 16'ha000;
      {LVL_Z, LVL_H}: pfc_sel = 16'h9000;
      {LVL_Z, LVL_Z}: pfc_sel = 16'h8400;
      {LVL_Z, LVL_L}: pfc_sel = 16'h7800;
      {LVL_L, LVL_H}: pfc_sel = 16'h6c00;
      {LVL_L, LVL_Z}: pfc_sel = 16'h6400;
      default: pfc_sel = 16'h5800;
    endcase
  endfunction
  // scale index 0..5 for 1/80 .. 1/2560 mVh per count
  function automatic logic [2:0] scale_sel(input logic [1:0] p3, input logic [1:0] p4);
    logic [2:0] lo;
    lo = (p3 == LVL_H) ? 3'h0 : (p3 == LVL_Z) ? 3'h1 : 3'h2;
    scale_sel = (p4 == LVL_Z) ? 3'(lo + 3'h3) : lo;
  endfunction
endpackage

// *** testbench/cc_gauge_chk.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module cc_gauge_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sense_above_filter,
  input wire logic cell_below_final,
  input wire logic cell_voltage_in_range,
  input wire logic [3:0] temp_step,
  input wire logic charge_control_out_n,
  input wire logic empty_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_range_off: assert property (
    !cell_voltage_in_range ##1 !cell_voltage_in_range |=> charge_control_out_n)
    else $error("charge output active with cell out of range");
  a_hot_off: assert property (
    temp_step >= 4'h9 ##1 temp_step >= 4'h9 |=> charge_control_out_n)
    else $error("charge output active while hot");
  a_hot_hold: assert property (
    temp_step >= 4'h9 ##1 (temp_step == 4'h8) [*3] |=> charge_control_out_n)
    else $error("charge output active before cooling");
  a_empty_set: assert property (
    cell_below_final |-> ##[1:2] empty_flag)
    else $error("empty flag not set");
  a_empty_hold: assert property (
    empty_flag && !sense_above_filter |=> empty_flag)
    else $error("empty flag dropped without charge");
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_read_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while busy");
endmodule // cc_gauge_chk
bind cc_gauge cc_gauge_chk cc_gauge_chk_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .sense_above_filter, .cell_below_final,
  .cell_voltage_in_range, .temp_step, .charge_control_out_n, .empty_flag);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, temp_step = 4'h6;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] full_count_a_pin = 2'h0, full_count_b_pin = 2'h0;
  logic [1:0] scale_a_pin = 2'h0, scale_b_pin = 2'h0, self_discharge_select_pin = 2'h2;
  logic [1:0] display_mode_pin = 2'h2, display_select_pin = 2'h2;
  logic charge_count_pulse = 1'h0, discharge_count_pulse = 1'h0;
  logic sense_above_filter = 1'h0, sense_above_4mv = 1'h0, sense_below_neg4mv = 1'h0;
  logic cell_below_early = 1'h0, cell_below_final = 1'h0, cell_voltage_in_range = 1'h1;
  logic charge_control_out_n, led_enable, empty_flag;
  logic [31:0] rd;
  logic [1:0] rs;
  int num_errors = 0, samples_checked = 0, available_charge_count, learned_capacity, discharge_counter, k;
  bit ed, arm, valid_discharge_flag;
  int programmed_full_count[9] = '{22528, 25600, 27648, 30720, 33792, 36864, 40960, 45056, 49152};
  int t_temp[6] = '{6, 6, 9, 8, 7, 6};
  bit t_rng[6] = '{1, 1, 1, 1, 1, 0};
  bit t_inh[6] = '{0, 1, 0, 0, 0, 0};
  bit t_out[6] = '{0, 1, 1, 1, 0, 1};

  cc_gauge #(.HALF_CYC(4), .TOPOFF_HALVES(6)) cc_gauge_inst (.*);

  always #5 aclk = ~aclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task rst;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task cmp_all;
    rd_reg(cc_pkg::REG_NAC);
    chk("nac", available_charge_count, rd);
    rd_reg(cc_pkg::REG_LMD);
    chk("lmd", learned_capacity, rd);
    rd_reg(cc_pkg::REG_DCR);
    chk("dcr", discharge_counter, rd);
  endtask
  // count pulses with the model following each one
  task pls(input bit c, input int n);
    int pre;
    repeat (n)
    begin
      if (c) charge_count_pulse <= 1'h1;
      else discharge_count_pulse <= 1'h1;
      @(posedge aclk);
      charge_count_pulse <= 1'h0;
      discharge_count_pulse <= 1'h0;
      pre = available_charge_count;
      if (c)
      begin
        if (available_charge_count < learned_capacity) available_charge_count++;
        if (arm && valid_discharge_flag) learned_capacity = discharge_counter;
        arm = 0;
      end
      else
      begin
        if (available_charge_count > 0) available_charge_count--;
        if (pre == learned_capacity) discharge_counter = 0;
        else if (!ed && discharge_counter < 65535) discharge_counter++;
      end
      @(posedge aclk);
      if (available_charge_count == learned_capacity) {discharge_counter, valid_discharge_flag} = {32'h0, 1'h1};
    end
  endtask
  task lows;
    k = 0;
    repeat (128)
    begin
      @(posedge aclk);
      k += (charge_control_out_n === 1'h0);
    end
  endtask
  task finish_test;
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(46));
    for (int i = 0; i < 9; i++)
    begin
      full_count_a_pin <= 2'(i / 3);
      full_count_b_pin <= 2'(i % 3);
      scale_a_pin <= 2'($urandom % 3);
      scale_b_pin <= 2'($urandom % 2);
      rst;
      rd_reg(cc_pkg::REG_LMD);
      chk("lmd", programmed_full_count[i], rd);
      rd_reg(cc_pkg::REG_NAC);
      chk("nac", programmed_full_count[i], rd);
      rd_reg(cc_pkg::REG_CFG);
      chk("scale", 32'(2 - scale_a_pin + 3 * scale_b_pin), 32'(rd[14:12]));
    end
    {full_count_a_pin, full_count_b_pin} <= 4'ha;
    for (int i = 0; i < 3; i++)
    begin
      self_discharge_select_pin <= 2'(i);
      display_select_pin <= 2'(i);
      sense_above_4mv <= 1'h1;
      rst;
      repeat (1000) @(posedge aclk);
      chk("led", 32'(i != 2), 32'(led_enable));
      sense_above_4mv <= 1'h0;
      repeat (4) @(posedge aclk);
      chk("led", 32'(i == 0), 32'(led_enable));
      rd_reg(cc_pkg::REG_NAC);
      chk("nac", 32'(49152 - (i != 2)), rd);
    end
    {full_count_a_pin, full_count_b_pin, display_mode_pin} <= 6'h15;
    {self_discharge_select_pin, display_select_pin} <= 4'h9;
    rst;
    {available_charge_count, learned_capacity, discharge_counter, ed, arm, valid_discharge_flag} = {32'd0, 32'd33792, 32'd0, 3'h0};
    pls(0, 5);
    cmp_all;
    display_mode_pin <= 2'h2;
    rst;
    {available_charge_count, discharge_counter, valid_discharge_flag} = {learned_capacity, 32'd0, 1'h1};
    pls(0, 40 + $urandom % 60);
    cmp_all;
    pls(1, 10);
    cmp_all;
    cell_below_early <= 1'h1;
    @(posedge aclk);
    cell_below_early <= 1'h0;
    @(posedge aclk);
    {available_charge_count, ed, arm} = {32'd0, 2'h3};
    pls(0, 5);
    cmp_all;
    pls(1, 1);
    cmp_all;
    pls(1, 150);
    cmp_all;
    wr(cc_pkg::REG_LMD, 32'h1234);
    cmp_all;
    rd_reg(8'h18);
    chk("rresp", cc_pkg::RESP_DECERR, rs);
    wr(8'h18, 32'h1);
    chk("bresp", cc_pkg::RESP_DECERR, rs);
    cell_below_final <= 1'h1;
    @(posedge aclk);
    cell_below_final <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("empty", 1, empty_flag);
    sense_above_filter <= 1'h1;
    pls(1, 256);
    chk("empty", 1, empty_flag);
    pls(1, 1);
    chk("empty", 0, empty_flag);
    sense_above_filter <= 1'h0;
    ed = 0;
    pls(0, learned_capacity / 2 + 1);
    for (int i = 0; i < 6; i++)
    begin
      temp_step <= 4'(t_temp[i]);
      cell_voltage_in_range <= t_rng[i];
      wr(cc_pkg::REG_CTRL, 32'(t_inh[i]));
      repeat (4) @(posedge aclk);
      chk("chg_n", 32'(t_out[i]), 32'(charge_control_out_n));
    end
    temp_step <= 4'h3;
    cell_voltage_in_range <= 1'h1;
    repeat (8) @(posedge aclk);
    lows;
    chk("lows", 8, k);
    temp_step <= 4'h6;
    pls(1, learned_capacity);
    repeat (200) @(posedge aclk);
    lows;
    chk("lows", 8, k);
    pls(0, 1);
    repeat (8) @(posedge aclk);
    lows;
    chk("lows", 8, k);
    cmp_all;
    finish_test;
  end
  initial
  begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    finish_test;
  end
endmodule // tb_top
